// File: rtl/waveform_timer_device.sv
`timescale 1ns/1ps
module waveform_timer_device
    import waveform_timer_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    waveform_timer_if.device bus,
    input wire logic osc_tick_i,
    input wire logic ext_tick_i,
    output logic wave_out_a_o,
    output logic wave_out_b_o,
    output logic wave_out_c_o,
    output logic wave_out_d_o,
    output logic fault_event_a_o,
    output logic fault_event_b_o
);
    // *****************************************************************
    // State
    // *****************************************************************
    logic [DATA_W-1:0] static_q [NUM_STATIC];
    logic [DATA_W-1:0] dbuf_q [NUM_DBUF];
    logic [DATA_W-1:0] core_q [NUM_DBUF];
    logic en_target;
    logic core_en;
    logic en_busy;
    logic cmd_busy;
    logic [CMD_W-1:0] cmd_q;
    logic [1:0] cross_cnt;
    logic [2:0] presc_cnt;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cap_a;
    logic [CNT_W-1:0] cap_b;
    logic [DATA_W-1:0] int_en;
    logic int_flag;
    logic [DATA_W-1:0] rdata;
    logic rvalid;

    // *****************************************************************
    // Address decode
    // *****************************************************************
    wire [IDX_W-1:0] idx = bus.addr[IDX_W-1:0];
    wire [1:0] page = bus.addr[ADDR_W-1:IDX_W];
    wire idx_ok = idx < IDX_W'(NUM_STATIC);
    wire in_static = (page == STATIC_PAGE) && idx_ok;
    wire in_dbuf = (page == DBUF_PAGE) && idx_ok;
    wire enable_ready = !en_busy && !cmd_busy;
    wire command_ready = !en_busy && !cmd_busy;
    wire ctrl_a_wr = bus.wr && in_static && (idx == CTRL_A_IDX);
    wire en_req = ctrl_a_wr && enable_ready
        && (bus.wdata[ENABLE_BIT] != en_target);
    wire static_wr_ok = bus.wr && in_static && !en_target;
    wire dbuf_wr_ok = bus.wr && in_dbuf && command_ready;
    wire cmd_wr_ok = bus.wr && (bus.addr == CMD_ADDR) && core_en
        && command_ready && (|bus.wdata[CMD_W-1:0]);
    wire flag_clr = bus.wr && (bus.addr == INT_FLAG_ADDR)
        && bus.wdata[INT_EOC_BIT];

    // *****************************************************************
    // Core clock selection and prescaler
    // *****************************************************************
    wire [1:0] core_clock_select = static_q[CTRL_A_IDX][CORE_CLOCK_SELECT_LSB+1:CORE_CLOCK_SELECT_LSB];
    wire [1:0] presc = static_q[CTRL_A_IDX][PRESC_LSB+1:PRESC_LSB];
    wire tick_src = (core_clock_select == CORE_CLOCK_SELECT_OSC) ? osc_tick_i
        : (core_clock_select == CORE_CLOCK_SELECT_EXT) ? ext_tick_i
        : (core_clock_select == CORE_CLOCK_SELECT_SYS);
    wire [2:0] presc_mask = 3'((4'h1 << presc) - 4'h1);
    wire core_tick = tick_src && ((presc_cnt & presc_mask) == 3'h0);

    // *****************************************************************
    // Crossing and core control
    // *****************************************************************
    // The crossing waits two core ticks, so a slow core clock stretches
    // the time both ready flags stay low.
    wire arrive = core_tick && (en_busy || cmd_busy)
        && (cross_cnt == CROSS_LAST);
    wire run_dbg = core_q[DEBUG_IDX][RUN_DBG_BIT];
    wire fault_dbg = core_q[DEBUG_IDX][FAULT_DBG_BIT];
    wire halt = bus.debug_halt && !run_dbg;
    wire run = core_en && !halt;
    wire [CNT_W-1:0] top = core_q[CMP_B_CLR_IDX][CNT_W-1:0];
    wire eoc = core_tick && run && (cnt >= top);
    wire eoc_idle = eoc && !cmd_busy;
    wire do_restart = arrive && cmd_busy && cmd_q[CMD_RESTART];
    wire copy_now = (arrive && en_busy && en_target)
        || (arrive && cmd_busy && cmd_q[CMD_SYNC])
        || (eoc_idle && cmd_q[CMD_SYNC_EOC]);
    wire [CNT_W-1:0] next_cnt = (do_restart || !core_en || eoc) ? '0
        : (run && core_tick) ? cnt + 1'b1 : cnt;
    wire [CNT_W-1:0] a_set = core_q[CMP_A_SET_IDX][CNT_W-1:0];
    wire [CNT_W-1:0] a_clr = core_q[CMP_A_CLR_IDX][CNT_W-1:0];
    wire [CNT_W-1:0] b_set = core_q[CMP_B_SET_IDX][CNT_W-1:0];
    wire next_a = core_en && (cnt >= a_set) && (cnt < a_clr);
    wire next_b = core_en && (cnt >= b_set) && (cnt < top);
    wire [CMD_W-1:0] eoc_bits = (CMD_W'(1) << CMD_SYNC_EOC)
        | (CMD_W'(1) << CMD_DIS_EOC);
    // A pending end-of-cycle bit is spent at that end even when a new
    // command lands in the same cycle, so it never acts twice
    wire [CMD_W-1:0] cmd_keep = (eoc_idle || !core_en) ? '0 : cmd_q;

    // *****************************************************************
    // Read data selection
    // *****************************************************************
    wire [DATA_W-1:0] ctrl_a_rd = {static_q[CTRL_A_IDX][DATA_W-1:1],
        en_target};
    wire [DATA_W-1:0] status_rd = DATA_W'({command_ready, enable_ready});
    wire [DATA_W-1:0] static_rd = (idx == CTRL_A_IDX) ? ctrl_a_rd
        : static_q[idx];
    wire [DATA_W-1:0] next_rdata = in_static ? static_rd
        : in_dbuf ? dbuf_q[idx]
        : (bus.addr == STATUS_ADDR) ? status_rd
        : (bus.addr == CAP_A_ADDR) ? DATA_W'(cap_a)
        : (bus.addr == CAP_B_ADDR) ? DATA_W'(cap_b)
        : (bus.addr == INT_EN_ADDR) ? int_en
        : (bus.addr == INT_FLAG_ADDR) ? DATA_W'(int_flag)
        : (bus.addr == CMD_ADDR) ? DATA_W'(cmd_q)
        : REG_RESET;

    assign bus.rdata = rdata;
    assign bus.rvalid = rvalid;

    // *****************************************************************
    // Register banks
    // *****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_STATIC; gi++)
        begin : g_regs
            always_ff @(posedge clk_sys_i)
            begin
                if (rst_i)
                begin
                    static_q[gi] <= REG_RESET;
                    dbuf_q[gi] <= REG_RESET;
                    core_q[gi] <= REG_RESET;
                end
                else
                begin
                    if (static_wr_ok && idx == IDX_W'(gi))
                        static_q[gi] <= bus.wdata;
                    if (dbuf_wr_ok && idx == IDX_W'(gi))
                        dbuf_q[gi] <= bus.wdata;
                    if (copy_now)
                        core_q[gi] <= dbuf_q[gi];
                end
            end
        end
    endgenerate

    // *****************************************************************
    // Enable and command crossing
    // *****************************************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            en_target <= 1'b0;
            core_en <= 1'b0;
            en_busy <= 1'b0;
            cmd_busy <= 1'b0;
            cmd_q <= '0;
            cross_cnt <= 2'h0;
        end
        else
        begin
            if (en_req)
            begin
                en_target <= bus.wdata[ENABLE_BIT];
                en_busy <= 1'b1;
            end
            else if (arrive && en_busy)
            begin
                core_en <= en_target;
                en_busy <= 1'b0;
            end
            else if (eoc_idle && cmd_q[CMD_DIS_EOC])
            begin
                core_en <= 1'b0;
                en_target <= 1'b0;
            end
            if (cmd_wr_ok)
            begin
                cmd_q <= cmd_keep | bus.wdata[CMD_W-1:0];
                cmd_busy <= 1'b1;
            end
            else if (arrive && cmd_busy)
            begin
                cmd_q <= cmd_q & eoc_bits;
                cmd_busy <= 1'b0;
            end
            else if (eoc_idle || !core_en)
                cmd_q <= '0;
            if (arrive || !(en_busy || cmd_busy))
                cross_cnt <= 2'h0;
            else if (core_tick)
                cross_cnt <= cross_cnt + 2'h1;
        end
    end

    // *****************************************************************
    // Core counter, captures and outputs
    // *****************************************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            presc_cnt <= 3'h0;
            cnt <= '0;
            cap_a <= '0;
            cap_b <= '0;
            wave_out_a_o <= 1'b0;
            wave_out_b_o <= 1'b0;
            wave_out_c_o <= 1'b0;
            wave_out_d_o <= 1'b0;
            fault_event_a_o <= 1'b0;
            fault_event_b_o <= 1'b0;
        end
        else
        begin
            if (tick_src)
                presc_cnt <= presc_cnt + 3'h1;
            cnt <= next_cnt;
            if (arrive && cmd_busy && cmd_q[CMD_CAP_A])
                cap_a <= cnt;
            if (arrive && cmd_busy && cmd_q[CMD_CAP_B])
                cap_b <= cnt;
            if (core_tick)
            begin
                wave_out_a_o <= next_a;
                wave_out_b_o <= next_b;
                wave_out_c_o <= next_a;
                wave_out_d_o <= next_b;
            end
            // Safeguard: held for the whole halt, released with it
            fault_event_a_o <= bus.debug_halt && fault_dbg;
            fault_event_b_o <= bus.debug_halt && fault_dbg;
        end
    end

    // *****************************************************************
    // Normal registers and read port
    // *****************************************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            int_en <= REG_RESET;
            int_flag <= 1'b0;
            rdata <= REG_RESET;
            rvalid <= 1'b0;
        end
        else
        begin
            if (bus.wr && bus.addr == INT_EN_ADDR)
                int_en <= bus.wdata;
            // Set wins over a clear in the same cycle
            int_flag <= eoc || (int_flag && !flag_clr);
            rvalid <= bus.rd;
            if (bus.rd)
                rdata <= next_rdata;
        end
    end
endmodule : waveform_timer_device

// File: inc/waveform_timer_pkg.sv
package waveform_timer_pkg;
    // *****************************************************************
    // Bus geometry
    // *****************************************************************
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int CNT_W = 12;
    localparam int NUM_STATIC = 9;
    localparam int NUM_DBUF = 9;
    localparam int IDX_W = 4;

    // *****************************************************************
    // Register map
    // *****************************************************************
    localparam logic [1:0] STATIC_PAGE = 2'h0;
    localparam logic [1:0] DBUF_PAGE = 2'h1;
    localparam logic [ADDR_W-1:0] CMD_ADDR = 6'h20;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 6'h21;
    localparam logic [ADDR_W-1:0] INT_EN_ADDR = 6'h22;
    localparam logic [ADDR_W-1:0] INT_FLAG_ADDR = 6'h23;
    localparam logic [ADDR_W-1:0] CAP_A_ADDR = 6'h24;
    localparam logic [ADDR_W-1:0] CAP_B_ADDR = 6'h25;
    localparam logic [ADDR_W-1:0] CTRL_A_ADDR = 6'h00;

    // Static page indices
    localparam logic [IDX_W-1:0] CTRL_A_IDX = 4'h0;
    // Double-buffered page indices
    localparam logic [IDX_W-1:0] DEBUG_IDX = 4'h4;
    localparam logic [IDX_W-1:0] CMP_A_SET_IDX = 4'h5;
    localparam logic [IDX_W-1:0] CMP_A_CLR_IDX = 4'h6;
    localparam logic [IDX_W-1:0] CMP_B_SET_IDX = 4'h7;
    localparam logic [IDX_W-1:0] CMP_B_CLR_IDX = 4'h8;

    // *****************************************************************
    // Fields
    // *****************************************************************
    localparam int ENABLE_BIT = 0;
    localparam int PRESC_LSB = 3;
    localparam int CORE_CLOCK_SELECT_LSB = 5;
    localparam logic [1:0] CORE_CLOCK_SELECT_OSC = 2'h0;
    localparam logic [1:0] CORE_CLOCK_SELECT_EXT = 2'h2;
    localparam logic [1:0] CORE_CLOCK_SELECT_SYS = 2'h3;
    localparam int ENABLE_READY_FLAG_BIT = 0;
    localparam int COMMAND_READY_ALIAS_BIT = 1;
    localparam int RUN_DBG_BIT = 0;
    localparam int FAULT_DBG_BIT = 2;
    localparam int INT_EOC_BIT = 0;
    localparam int CMD_W = 6;
    localparam int CMD_SYNC_EOC = 0;
    localparam int CMD_SYNC = 1;
    localparam int CMD_RESTART = 2;
    localparam int CMD_CAP_A = 3;
    localparam int CMD_CAP_B = 4;
    localparam int CMD_DIS_EOC = 5;

    // *****************************************************************
    // Reset values and timing
    // *****************************************************************
    localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
    localparam logic [1:0] CROSS_LAST = 2'h1;
endpackage : waveform_timer_pkg

// File: inc/waveform_timer_if.sv
`timescale 1ns/1ps
interface waveform_timer_if;
    import waveform_timer_pkg::*;
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic debug_halt;

    modport device
    (
        input wr, rd, addr, wdata, debug_halt,
        output rdata, rvalid
    );
    modport host
    (
        output wr, rd, addr, wdata, debug_halt,
        input rdata, rvalid
    );
endinterface : waveform_timer_if

// File: rtl/waveform_timer_host.sv
`timescale 1ns/1ps
module waveform_timer_host
    import waveform_timer_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    waveform_timer_if.host bus,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [DATA_W-1:0] req_data_i,
    input wire logic halt_i,
    output logic busy_o,
    output logic done_o,
    output logic [DATA_W-1:0] rdata_o
);
    // *****************************************************************
    // Sequencer
    // *****************************************************************
    typedef enum logic [2:0] {H_IDLE, H_POLL, H_CHECK, H_WRITE,
        H_READ} host_state_t;
    host_state_t state;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] bus_addr;
    logic [DATA_W-1:0] wdata;
    logic halt;

    wire need_en = req_addr_i == CTRL_A_ADDR;
    wire need_cmd = (req_addr_i == CMD_ADDR)
        || (req_addr_i[ADDR_W-1:IDX_W] == DBUF_PAGE);
    wire gated = req_write_i && (need_en || need_cmd);
    wire flag_bit = (addr == CTRL_A_ADDR) ? bus.rdata[ENABLE_READY_FLAG_BIT]
        : bus.rdata[COMMAND_READY_ALIAS_BIT];

    assign bus.wr = wr;
    assign bus.rd = rd;
    assign bus.addr = bus_addr;
    assign bus.wdata = wdata;
    assign bus.debug_halt = halt;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state <= H_IDLE;
            addr <= '0;
            data <= '0;
            wr <= 1'b0;
            rd <= 1'b0;
            bus_addr <= '0;
            wdata <= '0;
            halt <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= '0;
        end
        else
        begin
            halt <= halt_i;
            wr <= 1'b0;
            rd <= 1'b0;
            done_o <= 1'b0;
            unique case (state)
                H_IDLE:
                begin
                    if (req_i)
                    begin
                        addr <= req_addr_i;
                        data <= req_data_i;
                        busy_o <= 1'b1;
                        rd <= 1'b1;
                        bus_addr <= gated ? STATUS_ADDR : req_addr_i;
                        state <= !req_write_i ? H_READ
                            : gated ? H_CHECK : H_IDLE;
                        if (req_write_i && !gated)
                        begin
                            rd <= 1'b0;
                            wr <= 1'b1;
                            wdata <= req_data_i;
                            state <= H_WRITE;
                        end
                    end
                end
                H_POLL:
                begin
                    rd <= 1'b1;
                    bus_addr <= STATUS_ADDR;
                    state <= H_CHECK;
                end
                H_CHECK:
                begin
                    // Poll the ready flag until the crossing has acked
                    if (bus.rvalid)
                    begin
                        if (flag_bit)
                        begin
                            wr <= 1'b1;
                            bus_addr <= addr;
                            wdata <= data;
                            state <= H_WRITE;
                        end
                        else
                            state <= H_POLL;
                    end
                end
                H_WRITE:
                begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    state <= H_IDLE;
                end
                H_READ:
                begin
                    if (bus.rvalid)
                    begin
                        rdata_o <= bus.rdata;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        state <= H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : waveform_timer_host

// File: verification/waveform_timer_sva.sv
`timescale 1ns/1ps
module waveform_timer_sva
    import waveform_timer_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wr,
    input wire logic rd,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic rvalid,
    input wire logic debug_halt
);
    // ***********************************************************
    // Register bus protocol between host and device
    // ***********************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // Buffered page and command writes both wait on command ready
    wire cmd_sel = wr && (addr == CMD_ADDR || addr[5:4] == DBUF_PAGE);
    wire en_sel = wr && addr == CTRL_A_ADDR;

    sequence s_read_walk;
        rd ##1 (rvalid && !rd) ##1 !rvalid;
    endsequence
    sequence s_poll_ok(int b);
        $past(rvalid) && $past(rdata[b]) && $past(addr) == STATUS_ADDR;
    endsequence

    property p_read_answer;
        rd |-> s_read_walk;
    endproperty
    property p_rvalid_cause;
        rvalid |-> $past(rd);
    endproperty
    property p_wr_pulse;
        wr |=> !wr;
    endproperty
    property p_no_overlap;
        !(wr && rd);
    endproperty
    property p_unmapped;
        rd && addr >= 6'h26 |=> rdata == 16'h0000;
    endproperty
    property p_rdata_stands;
        !rvalid |-> $stable(rdata);
    endproperty
    property p_enable_gated;
        en_sel |-> s_poll_ok(ENABLE_READY_FLAG_BIT);
    endproperty
    property p_cmd_gated;
        cmd_sel |-> s_poll_ok(COMMAND_READY_ALIAS_BIT);
    endproperty

    a_read_answer: assert property (p_read_answer)
        else $error("read not answered one cycle later");
    a_rvalid_cause: assert property (p_rvalid_cause)
        else $error("read valid without a read");
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write strobe longer than one cycle");
    a_no_overlap: assert property (p_no_overlap)
        else $error("read and write strobes together");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_rdata_stands: assert property (p_rdata_stands)
        else $error("read data moved outside a read answer");
    a_enable_gated: assert property (p_enable_gated)
        else $error("control write without enable ready poll");
    a_cmd_gated: assert property (p_cmd_gated)
        else $error("command or buffer write without ready poll");
    c_cmd: cover property (cmd_sel);
endmodule : waveform_timer_sva

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import waveform_timer_pkg::*;
;
    logic clk_sys_i;
    logic rst_i = 1'b1;
    logic req_i = 1'b0;
    logic req_write_i = 1'b0;
    logic [ADDR_W-1:0] req_addr_i = 6'h00;
    logic [DATA_W-1:0] req_data_i = 16'h0000;
    logic halt_i = 1'b0;
    logic osc_tick_i = 1'b0;
    logic ext_tick_i = 1'b0;
    logic osc_on = 1'b0;
    logic ext_on = 1'b0;
    logic [1:0] ph = 2'h0;
    logic busy_o, done_o, wa, wb, wc, wd, fa, fb;
    logic [DATA_W-1:0] rdata_o;
    int err_total = 0;
    int compares = 0;

    waveform_timer_if bus_if();
    waveform_timer_host waveform_timer_host_i (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .bus(bus_if), .req_i(req_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i),
        .req_data_i(req_data_i), .halt_i(halt_i), .busy_o(busy_o),
        .done_o(done_o), .rdata_o(rdata_o));
    waveform_timer_device waveform_timer_device_i (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .bus(bus_if), .osc_tick_i(osc_tick_i),
        .ext_tick_i(ext_tick_i), .wave_out_a_o(wa), .wave_out_b_o(wb),
        .wave_out_c_o(wc), .wave_out_d_o(wd), .fault_event_a_o(fa),
        .fault_event_b_o(fb));
    waveform_timer_sva waveform_timer_sva_i (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .wr(bus_if.wr), .rd(bus_if.rd), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .rdata(bus_if.rdata),
        .rvalid(bus_if.rvalid), .debug_halt(bus_if.debug_halt));

    // ***********************************************************
    // Clock, core tick sources and shared tasks
    // ***********************************************************
    initial
    begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // Two tick rates, so a wrongly chosen source still shows motion
    always @(posedge clk_sys_i)
    begin
        ph <= ph + 2'h1;
        osc_tick_i <= #1 osc_on && ph[0];
        ext_tick_i <= #1 ext_on && ph == 2'h3;
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    task automatic check(input logic [DATA_W-1:0] got, exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    always @(negedge clk_sys_i)
    begin
        if (rst_i === 1'b0)
        begin
            check({14'h0, wc, wd}, {14'h0, wa, wb});
            check({15'h0, wa & wb}, 16'h0000);
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : tick

    task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        int n;
        tick(1);
        req_i = 1'b1;
        req_write_i = w;
        req_addr_i = a;
        req_data_i = d;
        tick(1);
        req_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 4000)
        begin
            tick(1);
            n++;
        end
        if (n >= 4000)
            check(16'h0000, 16'h0001);
        check({15'h0, busy_o}, 16'h0000);
        q = rdata_o;
    endtask : bus

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] q;
        bus(1'b0, a, 16'h0000, q);
        check(q, e);
    endtask : rd_chk

    // Judges whether wave output A moves at all within n cycles
    task automatic activity(input int n, input logic want);
        logic last;
        int t;
        t = 0;
        @(negedge clk_sys_i);
        last = wa;
        repeat (n)
        begin
            @(negedge clk_sys_i);
            if (wa !== last)
                t++;
            last = wa;
        end
        check({15'h0, t > 0}, {15'h0, want});
    endtask : activity

    // ***********************************************************
    // Scenarios
    // ***********************************************************
    task automatic t_reset;
        rd_chk(STATUS_ADDR, 16'h0003);
        rd_chk(CTRL_A_ADDR, REG_RESET);
        rd_chk(6'h3f, 16'h0000);
        wr(INT_EN_ADDR, 16'h0001);
        rd_chk(INT_EN_ADDR, 16'h0001);
    endtask : t_reset

    task automatic t_setup;
        wr(CTRL_A_ADDR, 16'h0060);
        wr(6'h01, 16'h00a5);
        wr({DBUF_PAGE, CMP_A_SET_IDX}, 16'h0002);
        wr({DBUF_PAGE, CMP_A_CLR_IDX}, 16'h0005);
        wr({DBUF_PAGE, CMP_B_SET_IDX}, 16'h0006);
        wr({DBUF_PAGE, CMP_B_CLR_IDX}, 16'h0009);
        wr(CTRL_A_ADDR, 16'h0061);
        rd_chk(CTRL_A_ADDR, 16'h0061);
        wr(6'h01, 16'h005a);
        rd_chk(6'h01, 16'h00a5);
        wr(CTRL_A_ADDR, 16'h0041);
        rd_chk(CTRL_A_ADDR, 16'h0061);
        activity(100, 1'b1);
        rd_chk(INT_FLAG_ADDR, 16'h0001);
    endtask : t_setup

    task automatic t_sync;
        wr({DBUF_PAGE, CMP_A_CLR_IDX}, 16'h0000);
        activity(60, 1'b1);
        wr(CMD_ADDR, 16'h0001 << CMD_SYNC);
        tick(30);
        activity(60, 1'b0);
        wr({DBUF_PAGE, CMP_A_CLR_IDX}, 16'h0005);
        wr(CMD_ADDR, 16'h0001 << CMD_SYNC_EOC);
        tick(40);
        activity(60, 1'b1);
        rd_chk(CMD_ADDR, 16'h0000);
    endtask : t_sync

    task automatic t_cmds;
        // Restart zeroes the count five cycles before the capture lands
        wr(CMD_ADDR, 16'h0001 << CMD_RESTART);
        wr(CMD_ADDR, 16'h0001 << CMD_CAP_A);
        rd_chk(CAP_A_ADDR, 16'h0004);
        rd_chk(CMD_ADDR, 16'h0000);
        wr(CMD_ADDR, 16'h0001 << CMD_RESTART);
        wr(CMD_ADDR, 16'h0001 << CMD_CAP_B);
        rd_chk(CAP_B_ADDR, 16'h0004);
        rd_chk(CMD_ADDR, 16'h0000);
    endtask : t_cmds

    task automatic t_source(input logic [1:0] sel, input logic own_osc);
        logic [DATA_W-1:0] cfg;
        cfg = {9'h0, sel, 5'h00};
        wr(CTRL_A_ADDR, 16'h0060);
        rd_chk(CTRL_A_ADDR, 16'h0060);
        activity(40, 1'b0);
        check({15'h0, wa}, 16'h0000);
        wr(CTRL_A_ADDR, cfg);
        osc_on = own_osc;
        ext_on = !own_osc;
        wr(CTRL_A_ADDR, cfg | 16'h0001);
        rd_chk(STATUS_ADDR, 16'h0000);
        activity(100, 1'b1);
        osc_on = !own_osc;
        ext_on = own_osc;
        tick(10);
        activity(60, 1'b0);
        osc_on = own_osc;
        ext_on = !own_osc;
        wr(CTRL_A_ADDR, 16'h0060);
        // Fields stay locked while enabled, only the enable bit drops
        rd_chk(CTRL_A_ADDR, cfg);
    endtask : t_source

    task automatic t_debug;
        wr({DBUF_PAGE, DEBUG_IDX}, 16'h0004);
        wr(CMD_ADDR, 16'h0001 << CMD_SYNC);
        tick(10);
        halt_i = 1'b1;
        tick(4);
        check({14'h0, fa, fb}, 16'h0003);
        activity(40, 1'b0);
        check({14'h0, fa, fb}, 16'h0003);
        tick(1);
        halt_i = 1'b0;
        tick(4);
        check({14'h0, fa, fb}, 16'h0000);
        wr({DBUF_PAGE, DEBUG_IDX}, 16'h0001);
        wr(CMD_ADDR, 16'h0001 << CMD_SYNC);
        tick(10);
        halt_i = 1'b1;
        tick(4);
        activity(60, 1'b1);
        check({14'h0, fa, fb}, 16'h0000);
        tick(1);
        halt_i = 1'b0;
    endtask : t_debug

    task automatic t_disable_end_of_cycle;
        wr(CMD_ADDR, 16'h0001 << CMD_DIS_EOC);
        tick(30);
        rd_chk(CTRL_A_ADDR, 16'h0060);
        rd_chk(CMD_ADDR, 16'h0000);
    endtask : t_disable_end_of_cycle

    initial
    begin
        #200000;
        err_total++;
        complete_run();
    end

    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        t_reset();
        t_setup();
        t_sync();
        t_cmds();
        t_source(CORE_CLOCK_SELECT_OSC, 1'b1);
        t_source(CORE_CLOCK_SELECT_EXT, 1'b0);
        wr(CTRL_A_ADDR, 16'h0061);
        activity(60, 1'b1);
        t_debug();
        t_disable_end_of_cycle();
        complete_run();
    end
endmodule : tb_top
